// *** fitm_pkg.sv ***
/*
 Shared constants and types for the fruit interface host port.
 Assumes one 100 MHz clock and an AHB-Lite register slave.
*/
`default_nettype none
package fitm_pkg;
    localparam int WORD_W = 16;
    localparam int GROUP_LEN = 4;
    localparam int CLK_PERIOD_NS = 10;

    // Mode encodings held in the mode register
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_GEN_DIAG = 2'h1;
    localparam logic [1:0] MODE_XMIT_DIAG = 2'h2;
    localparam logic [1:0] MODE_LOOP = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_NORMAL;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INIT = 8'h08;

    // Field positions
    localparam int MODE_LSB = 0;
    localparam int INIT_BIT = 0;
    localparam int ST_OUT_BIT = 0;
    localparam int ST_IN_BIT = 1;
    localparam int ST_OUT_ADDR_LSB = 4;
    localparam int ST_IN_ADDR_LSB = 8;
    localparam int ST_MODE_LSB = 12;

    // Reset values, address base bit and counter limits
    localparam logic OUT_STATUS_INIT = 1'b0;
    localparam logic IN_STATUS_INIT = 1'b1;
    localparam logic ADDR_BASE_BIT = 1'b1;
    localparam logic [1:0] IDX_INIT = 2'h0;
    localparam logic [1:0] IDX_LAST = 2'h3;
    localparam logic [2:0] BURST_LAST = 3'h3;

    // Host pin positions in the synchronised pulse vector
    localparam int PIN_DOUT = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_CTRL = 2;
    localparam int PIN_INIT = 3;
    localparam int PIN_N = 4;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_READ = 3'b010,
        SEQ_WRITE = 3'b100
    } fitm_seq_type;

    typedef struct packed {
        logic read_pulse;
        logic write_pulse;
        logic [WORD_W-1:0] write_data;
    } fitm_ctl_req_type;

    typedef struct packed {
        logic read_valid;
        logic [WORD_W-1:0] read_data;
        logic write_strobe;
        logic input_addr_advance;
        logic out_status;
        logic in_status;
        logic [1:0] mode;
    } fitm_ctl_rsp_type;
endpackage
`default_nettype wire

// *** fitm_host_port.sv ***
/*
 Fruit interface host port: two four-word mailboxes between the host CPU
 pins and the controller, with normal, generator diagnostic, transmitter
 diagnostic and loop-test modes, plus an AHB-Lite register slave.
 Assumes host pins are asynchronous and the controller runs on hclk.
*/
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fitm_host_port
    import fitm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic host_data_out_pulse,
    input wire logic host_data_in_pulse,
    input wire logic host_control_out,
    input wire logic host_init_pulse,
    input wire logic [WORD_W-1:0] host_wdata,
    output logic [WORD_W-1:0] host_rdata,
    input wire fitm_ctl_req_type ctl_req,
    output fitm_ctl_rsp_type ctl_rsp
);

    function automatic logic group_end(input logic [1:0] idx);
        return idx == IDX_LAST;
    endfunction

    function automatic logic [2:0] location(input logic [1:0] idx);
        return {ADDR_BASE_BIT, idx};
    endfunction

    // A group end hands the memory to the other side, except in loop test
    function automatic logic hand_over(input logic [1:0] idx, input logic loop_on);
        return group_end(idx) && !loop_on;
    endfunction

    logic [PIN_N-1:0] pin_s1_reg;
    logic [PIN_N-1:0] pin_s2_reg;
    logic [PIN_N-1:0] pin_s3_reg;
    logic [WORD_W-1:0] data_s1_reg;
    logic [WORD_W-1:0] data_s2_reg;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;

    logic [1:0] mode_reg;
    logic [1:0] out_idx_reg;
    logic [1:0] in_idx_reg;
    logic out_status_reg;
    logic in_status_reg;
    logic [WORD_W-1:0] out_mem [GROUP_LEN];
    logic [WORD_W-1:0] in_mem [GROUP_LEN];
    fitm_seq_type seq_reg;
    logic [2:0] burst_reg;

    logic pend_reg;
    logic pend_write_reg;
    logic [7:0] pend_addr_reg;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [31:0] hrdata_reg;
    logic [WORD_W-1:0] host_rdata_reg;
    logic rsp_read_valid_reg;
    logic [WORD_W-1:0] rsp_read_data_reg;
    logic rsp_write_strobe_reg;
    logic rsp_advance_reg;
    logic rsp_out_status_reg;
    logic rsp_in_status_reg;
    logic [1:0] rsp_mode_reg;

    logic loop;
    logic ctl_rd_ok;
    logic ctl_wr_ok;
    logic ctl_reading;
    logic ctl_writing;
    logic init;
    logic sw_mode_we;
    logic sw_init;
    logic out_step;
    logic in_step;
    logic in_we;
    logic [WORD_W-1:0] in_mux;
    logic [31:0] status_word;
    logic [31:0] read_word;

    // Two-flop synchronisers; the third stage only serves the edge detectors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            data_s1_reg <= '0;
            data_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {host_init_pulse, host_control_out,
                           host_data_in_pulse, host_data_out_pulse};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            data_s1_reg <= host_wdata;
            data_s2_reg <= data_s1_reg;
        end
    end

    // Every host pulse becomes one-cycle strobes, so a long pulse steps once
    assign rise = pin_s2_reg & ~pin_s3_reg;
    assign fall = ~pin_s2_reg & pin_s3_reg;

    assign loop = mode_reg == MODE_LOOP;
    // Controller pulses are muted in loop test; only the generator
    // diagnostic mode uses the controller-to-CPU channel
    assign ctl_rd_ok = !loop && out_status_reg;
    assign ctl_wr_ok = (mode_reg == MODE_GEN_DIAG) && in_status_reg;

    assign sw_mode_we = pend_reg && pend_write_reg && pend_addr_reg == OFS_MODE;
    assign sw_init = pend_reg && pend_write_reg && pend_addr_reg == OFS_INIT
                     && hwdata[INIT_BIT];
    assign init = rise[PIN_INIT] || sw_init;

    // Mode register: host control pulse or software; software wins a tie
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_RESET;
        end else if (sw_mode_we) begin
            mode_reg <= hwdata[MODE_LSB +: 2];
        end else if (rise[PIN_CTRL]) begin
            mode_reg <= data_s2_reg[MODE_LSB +: 2];
        end
    end

    // Controller transfer sequencer: four consecutive word cycles per burst
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_reg <= SEQ_IDLE;
            burst_reg <= '0;
        end else if (init) begin
            seq_reg <= SEQ_IDLE;
            burst_reg <= '0;
        end else begin
            case (seq_reg)
                SEQ_IDLE: begin
                    burst_reg <= BURST_LAST;
                    if (ctl_req.read_pulse && ctl_rd_ok) begin
                        seq_reg <= SEQ_READ;
                    end else if (ctl_req.write_pulse && ctl_wr_ok) begin
                        seq_reg <= SEQ_WRITE;
                    end
                end
                SEQ_READ, SEQ_WRITE: begin
                    if (burst_reg == '0) begin
                        seq_reg <= SEQ_IDLE;
                    end else begin
                        burst_reg <= burst_reg - 3'h1;
                    end
                end
                default: begin
                    seq_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign ctl_reading = seq_reg == SEQ_READ;
    assign ctl_writing = seq_reg == SEQ_WRITE;

    // Output channel: CPU writes on the rising strobe, steps on the falling one
    assign out_step = fall[PIN_DOUT] || ctl_reading;

    always_ff @(posedge hclk) begin
        if (rise[PIN_DOUT]) begin
            out_mem[out_idx_reg] <= data_s2_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_idx_reg <= IDX_INIT;
            out_status_reg <= OUT_STATUS_INIT;
        end else if (init) begin
            out_idx_reg <= IDX_INIT;
            out_status_reg <= OUT_STATUS_INIT;
        end else if (out_step) begin
            out_idx_reg <= out_idx_reg + 2'h1;
            // Status hands the memory over after a full group; frozen in loop
            if (hand_over(out_idx_reg, loop)) begin
                out_status_reg <= ~out_status_reg;
            end
        end
    end

    // Input channel: loop test mirrors the just-written output word
    assign in_mux = loop ? out_mem[out_idx_reg] : ctl_req.write_data;
    assign in_we = ctl_writing || (loop && fall[PIN_DOUT]);
    assign in_step = fall[PIN_DIN] || ctl_writing
                     || (loop && fall[PIN_DOUT]);

    always_ff @(posedge hclk) begin
        if (in_we) begin
            in_mem[in_idx_reg] <= in_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_idx_reg <= IDX_INIT;
            in_status_reg <= IN_STATUS_INIT;
        end else if (init) begin
            in_idx_reg <= IDX_INIT;
            in_status_reg <= IN_STATUS_INIT;
        end else if (in_step) begin
            in_idx_reg <= in_idx_reg + 2'h1;
            if (hand_over(in_idx_reg, loop)) begin
                in_status_reg <= ~in_status_reg;
            end
        end
    end

    // Host read data follows the word the input counter points at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_rdata_reg <= '0;
        end else begin
            host_rdata_reg <= in_mem[in_idx_reg];
        end
    end

    // Controller-side outputs, one cycle behind the sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_read_valid_reg <= 1'b0;
            rsp_read_data_reg <= '0;
        end else begin
            rsp_read_valid_reg <= ctl_reading;
            rsp_read_data_reg <= out_mem[out_idx_reg];
        end
    end

    // One four-cycle advance pulse rides along the four-cycle write strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_write_strobe_reg <= 1'b0;
            rsp_advance_reg <= 1'b0;
        end else begin
            rsp_write_strobe_reg <= ctl_writing;
            rsp_advance_reg <= ctl_writing;
        end
    end

    // Status and mode are mirrored so the controller can poll them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_out_status_reg <= 1'b0;
            rsp_in_status_reg <= 1'b0;
            rsp_mode_reg <= '0;
        end else begin
            rsp_out_status_reg <= out_status_reg;
            rsp_in_status_reg <= in_status_reg;
            rsp_mode_reg <= mode_reg;
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_OUT_BIT] = out_status_reg;
        status_word[ST_IN_BIT] = in_status_reg;
        status_word[ST_OUT_ADDR_LSB +: 3] = location(out_idx_reg);
        status_word[ST_IN_ADDR_LSB +: 3] = location(in_idx_reg);
        status_word[ST_MODE_LSB +: 2] = mode_reg;
    end

    always_comb begin
        read_word = '0;
        case (pend_addr_reg)
            OFS_MODE: read_word[MODE_LSB +: 2] = mode_reg;
            OFS_STATUS: read_word = status_word;
            default: read_word = '0;
        endcase
    end

    // AHB-Lite slave: one wait state on every transfer so read data is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg <= 1'b0;
            pend_write_reg <= 1'b0;
            pend_addr_reg <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= '0;
        end else if (pend_reg) begin
            pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= pend_write_reg ? 32'h0000_0000 : read_word;
        end else if (hready && hsel && htrans[1]) begin
            pend_reg <= 1'b1;
            pend_write_reg <= hwrite;
            pend_addr_reg <= {haddr[7:2], 2'b00};
            hreadyout_reg <= 1'b0;
        end
    end

    // Only word transfers are defined; hsize is accepted but not checked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign host_rdata = host_rdata_reg;
    always_comb begin
        ctl_rsp.read_valid = rsp_read_valid_reg;
        ctl_rsp.read_data = rsp_read_data_reg;
        ctl_rsp.write_strobe = rsp_write_strobe_reg;
        ctl_rsp.input_addr_advance = rsp_advance_reg;
        ctl_rsp.out_status = rsp_out_status_reg;
        ctl_rsp.in_status = rsp_in_status_reg;
        ctl_rsp.mode = rsp_mode_reg;
    end

endmodule
`default_nettype wire

// *** fitm_checker.sv ***
/*
 Concurrent checks on the fruit interface host port.
 Assumes it is bound to fitm_host_port and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module fitm_checker
    import fitm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire fitm_ctl_rsp_type ctl_rsp
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic ws = ctl_rsp.write_strobe;
    wire logic rv = ctl_rsp.read_valid;

    a_strobe_four_wide: assert property ($rose(ws) |-> ws [*4] ##1 !ws)
        else $error("write strobe not four cycles");
    a_advance_with_strobe: assert property (ctl_rsp.input_addr_advance == ws)
        else $error("advance differs from strobe");
    a_read_four_wide: assert property ($rose(rv) |-> rv [*4] ##1 !rv)
        else $error("read burst not four words");
    a_read_when_granted: assert property ($rose(rv) |-> ctl_rsp.out_status)
        else $error("read without grant");
    a_read_hands_back: assert property ($fell(rv) |-> !ctl_rsp.out_status)
        else $error("output status not returned");
    a_write_diag_only: assert property ($rose(ws) |->
        ctl_rsp.mode == MODE_GEN_DIAG && ctl_rsp.in_status)
        else $error("write outside generator diag");
    a_loop_ctl_muted: assert property (ctl_rsp.mode == MODE_LOOP |->
        !$rose(rv) && !$rose(ws))
        else $error("controller active in loop");
    a_loop_status_held: assert property (ctl_rsp.mode == MODE_LOOP &&
        $past(ctl_rsp.mode) == MODE_LOOP |->
        $stable({ctl_rsp.out_status, ctl_rsp.in_status}))
        else $error("status moved in loop");
    a_ready_one_low: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    a_resp_okay: assert property (!hresp)
        else $error("error response");

    cover property ($rose(ws));
    cover property ($fell(rv));
    cover property (ctl_rsp.mode == MODE_LOOP);
endmodule

bind fitm_host_port fitm_checker i_fitm_checker (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .ctl_rsp(ctl_rsp));
`default_nettype wire

// *** fitm_ctl_model.sv ***
/*
 Behavioural controller facing the mailboxes.
 Assumes hclk is shared; the bench calls its tasks just after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module fitm_ctl_model
    import fitm_pkg::*;
(
    input wire logic hclk,
    input wire fitm_ctl_rsp_type ctl_rsp,
    output fitm_ctl_req_type ctl_req
);
    logic [WORD_W-1:0] rx [4];
    initial ctl_req = '0;

    // Reads only once the output mailbox is handed over; stall models a slow side
    task automatic read_group(input int stall);
        int k;
        k = 0;
        repeat (stall) @(posedge hclk);
        while (ctl_rsp.out_status !== 1'b1) @(posedge hclk);
        ctl_req.read_pulse <= 1'b1;
        @(posedge hclk);
        ctl_req.read_pulse <= 1'b0;
        while (k < 4) begin
            @(posedge hclk);
            if (ctl_rsp.read_valid === 1'b1) begin
                rx[k] = ctl_rsp.read_data;
                k++;
            end
        end
    endtask

    // Released data line shows the inverse so stale words never match
    task automatic write_group(input logic [WORD_W-1:0] w [4]);
        while (ctl_rsp.in_status !== 1'b1) @(posedge hclk);
        ctl_req.write_pulse <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge hclk);
            ctl_req.write_pulse <= 1'b0;
            ctl_req.write_data <= w[k];
        end
        @(posedge hclk);
        ctl_req.write_data <= ~w[3];
    endtask
endmodule
`default_nettype wire

// *** fitm_host_port_tb.sv ***
/*
 Self-checking bench for the fruit interface host port.
 Assumes the checker and controller model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module fitm_host_port_tb
    import fitm_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0, m;
    logic [2:0] hsize = 3'h2;
    logic [3:0] pins = '0;
    logic [WORD_W-1:0] host_wdata = '0, host_rdata;
    logic [WORD_W-1:0] w [4];
    fitm_ctl_req_type ctl_req;
    fitm_ctl_rsp_type ctl_rsp;
    int num_errors = 0, n_compared = 0, cyc = 0;

    fitm_host_port i_fitm_host_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .host_data_out_pulse(pins[PIN_DOUT]), .host_data_in_pulse(pins[PIN_DIN]),
        .host_control_out(pins[PIN_CTRL]), .host_init_pulse(pins[PIN_INIT]),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .ctl_req(ctl_req),
        .ctl_rsp(ctl_rsp));
    fitm_ctl_model i_fitm_ctl_model (.hclk(hclk), .ctl_rsp(ctl_rsp), .ctl_req(ctl_req));

    initial begin
        forever #5 hclk = ~hclk;
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkw(input logic [WORD_W-1:0] got, exp);
        chk({16'h0000, got}, {16'h0000, exp});
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Data is set up three cycles ahead so the synchroniser sees it settled
    task automatic pulse(input int p, input logic [WORD_W-1:0] d);
        host_wdata <= d;
        repeat (3) @(posedge hclk);
        pins[p] <= 1'b1;
        repeat (4) @(posedge hclk);
        pins[p] <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask

    function automatic logic [31:0] st(input logic [1:0] md, input logic [2:0] il, ol,
            input logic i, o);
        return {18'h0_0000, md, 1'b0, il, 1'b0, ol, 2'h0, i, o};
    endfunction

    task automatic status(input logic [31:0] exp);
        ahb(1'b0, OFS_STATUS, '0);
        chk(rd, exp);
    endtask

    initial begin
        void'($urandom(40));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        status(st(MODE_NORMAL, 3'h4, 3'h4, 1'b1, 1'b0));
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h0C, '0);
        chk(rd, 32'h0000_0000);
        $display("test reset done");
        for (int j = 0; j < 3; j++) begin
            m = 2'(j);
            ahb(1'b1, OFS_MODE, {30'h0, m});
            for (int k = 0; k < 4; k++) begin
                w[k] = 16'($urandom);
                pulse(PIN_DOUT, w[k]);
                if (k == 0) status(st(m, 3'h4, 3'h5, 1'b1, 1'b0));
            end
            status(st(m, 3'h4, 3'h4, 1'b1, 1'b1));
            i_fitm_ctl_model.read_group(j * 3);
            for (int k = 0; k < 4; k++) chkw(i_fitm_ctl_model.rx[k], w[k]);
            status(st(m, 3'h4, 3'h4, 1'b1, 1'b0));
            for (int k = 0; k < 4; k++) w[k] = 16'($urandom);
            i_fitm_ctl_model.write_group(w);
            repeat (4) @(posedge hclk);
            status(st(m, 3'h4, 3'h4, m != MODE_GEN_DIAG, 1'b0));
            if (m == MODE_GEN_DIAG) begin
                for (int k = 0; k < 4; k++) begin
                    chkw(host_rdata, w[k]);
                    pulse(PIN_DIN, 16'h0000);
                end
                status(st(m, 3'h4, 3'h4, 1'b1, 1'b0));
            end
            $display("test mode %0d done", m);
        end
        pulse(PIN_CTRL, {14'h0, MODE_LOOP});
        ahb(1'b0, OFS_MODE, '0);
        chk(rd, 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            w[k] = 16'($urandom);
            pulse(PIN_DOUT, w[k]);
        end
        for (int k = 0; k < 5; k++) begin
            chkw(host_rdata, w[k % 4]);
            pulse(PIN_DIN, 16'h0000);
        end
        i_fitm_ctl_model.write_group(w);
        repeat (4) @(posedge hclk);
        status(st(MODE_LOOP, 3'h5, 3'h4, 1'b1, 1'b0));
        pulse(PIN_INIT, 16'h0000);
        status(st(MODE_LOOP, 3'h4, 3'h4, 1'b1, 1'b0));
        ahb(1'b1, OFS_MODE, 32'h0000_0000);
        pulse(PIN_DOUT, 16'($urandom));
        ahb(1'b1, OFS_INIT, 32'h0000_0001);
        status(st(MODE_NORMAL, 3'h4, 3'h4, 1'b1, 1'b0));
        $display("test loop and init done");
        give_verdict();
    end
endmodule
`default_nettype wire
